// ==== hw/sotc_settle_timer.sv ====
/*
 * Settle timer: after a start pulse, waits BASE times two to the select
 * cycles and gives a one-cycle expire pulse.
 * Assumes a start while busy restarts the wait.
 */
`timescale 1ns/1ps
module sotc_settle_timer #(
    parameter int BASE = sotc_pkg::SETTLE_BASE_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_start,
    input  wire logic [2:0] i_sel,
    output logic            o_expired
);

    // =========================================================================
    // Prescaler gives a one-cycle tick every BASE cycles while busy.
    localparam logic [15:0] PRE_LAST = 16'(BASE - 1);
    logic        busy_ff;
    logic [15:0] pre_ff;
    logic [7:0]  ticks_ff;
    logic [2:0]  sel_ff;
    logic        tick;

    assign tick      = busy_ff && pre_ff == PRE_LAST;
    assign o_expired = tick && ticks_ff == ((8'h01 << sel_ff) - 8'h01);

    always_ff @(posedge i_clock) begin
        if (i_srst || i_start) begin
            pre_ff <= 16'h0000;
        end else if (busy_ff) begin
            pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
        end
    end

    // Select is latched so a late register change cannot stretch a wait under way.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            busy_ff  <= 1'h0;
            ticks_ff <= 8'h00;
            sel_ff   <= 3'h0;
        end else if (i_start) begin
            busy_ff  <= 1'h1;
            ticks_ff <= 8'h00;
            sel_ff   <= i_sel;
        end else if (o_expired) begin
            busy_ff  <= 1'h0;
        end else if (tick) begin
            ticks_ff <= ticks_ff + 8'h01;
        end
    end

    // =========================================================================
    // Checks.
    logic [23:0] since_start_ff;
    always_ff @(posedge i_clock) begin
        if (i_srst || i_start) begin
            since_start_ff <= 24'h000000;
        end else begin
            since_start_ff <= since_start_ff + 24'h000001;
        end
    end

    a_settle_wait: assert property (@(posedge i_clock) disable iff (i_srst) // [R5]
        o_expired |-> since_start_ff == (24'(BASE) << sel_ff) - 24'h000001)
        else $error("Settle wait length wrong.");

endmodule : sotc_settle_timer

// ==== hw/sotc_spi_port.sv ====
/*
 * Serial register port: turns 24-bit frames into one-cycle register requests
 * and shifts read data back out MSB first.
 * Assumes the port pins are synchronous to i_clock and the serial clock is
 * slower than a quarter of it; bit 23 of a frame high means read.
 */
`timescale 1ns/1ps
module sotc_spi_port (
    input  wire logic                       i_clock,
    input  wire logic                       i_srst,
    input  wire logic                       i_spi_cs_n,
    input  wire logic                       i_spi_sclk,
    input  wire logic                       i_spi_sdi,
    input  wire logic [7:0]                 i_rdata,
    output sotc_pkg::sotc_reg_req_type      o_req,
    output logic                            o_spi_sdo,
    output logic                            o_spi_sdo_oe
);

    // =========================================================================
    // Frame capture.
    logic        sclk_prev_ff;
    logic [4:0]  bit_cnt_ff;
    logic [22:0] in_shift_ff;
    logic        rw_ff;
    logic [14:0] addr_ff;
    logic [7:0]  out_shift_ff;
    logic        sdo_oe_ff;
    logic        rise;

    assign rise = i_spi_sclk & ~sclk_prev_ff & ~i_spi_cs_n;

    // Edge detect on the serial clock; pins are already in this domain.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sclk_prev_ff <= 1'h0;
        end else begin
            sclk_prev_ff <= i_spi_sclk;
        end
    end

    // Bit counter saturates so trailing clocks in a long frame do nothing.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_spi_cs_n) begin
            bit_cnt_ff  <= 5'h00;
            in_shift_ff <= 23'h000000;
        end else if (rise && bit_cnt_ff != sotc_pkg::SPI_FRAME_END) begin
            bit_cnt_ff  <= bit_cnt_ff + 5'h01;
            in_shift_ff <= {in_shift_ff[21:0], i_spi_sdi};
        end
    end

    // Header latch and request pulses, registered for one cycle.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rw_ff   <= 1'h0;
            addr_ff <= 15'h0000;
            o_req   <= '0;
        end else begin
            o_req.wr <= 1'h0;
            o_req.rd <= 1'h0;
            if (rise && bit_cnt_ff == sotc_pkg::SPI_HDR_LAST) begin
                rw_ff      <= in_shift_ff[14];
                addr_ff    <= {in_shift_ff[13:0], i_spi_sdi};
                o_req.addr <= {in_shift_ff[13:0], i_spi_sdi};
                o_req.rd   <= in_shift_ff[14];
            end else if (rise && bit_cnt_ff == sotc_pkg::SPI_FRAME_LAST && !rw_ff) begin
                o_req.addr <= addr_ff;
                o_req.data <= {in_shift_ff[6:0], i_spi_sdi};
                o_req.wr   <= 1'h1;
            end
        end
    end

    // Read data loads when the read pulse is out and shifts after each data sample edge but the last.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_spi_cs_n) begin
            out_shift_ff <= 8'h00;
            sdo_oe_ff    <= 1'h0;
        end else if (o_req.rd) begin
            out_shift_ff <= i_rdata;
            sdo_oe_ff    <= 1'h1;
        end else if (rise && bit_cnt_ff >= sotc_pkg::SPI_DATA_FIRST && bit_cnt_ff <= sotc_pkg::SPI_DATA_SHIFT) begin
            out_shift_ff <= {out_shift_ff[6:0], 1'h0};
        end
    end

    assign o_spi_sdo    = out_shift_ff[7];
    assign o_spi_sdo_oe = sdo_oe_ff;

endmodule : sotc_spi_port

// ==== hw/sotc_top.sv ====
/*
 * Oscillator tune controller top: register file behind the serial port,
 * the synthesizer hold and the successive-approximation trim engine.
 * Assumes i_osc_fast is a synchronous flag from the frequency detector that
 * is high while the oscillator runs above its target for the present trim.
 */
// What this block and its software do
// [R1] A 7-bit trim code sets the oscillator frequency and the engine may write it.
// [R2] After tuning the trim register reads back the tuned code for later restore.
// [R3] Software keeps away from the trim register while a run is under way.
// [R4] Software sets the hold bit before reprogramming the synthesizer and clears it after.
// [R5] Each trim step is followed by a settle wait set by a 3-bit select resetting to four.
// [R6] With tuning enabled, clearing the hold bit starts a tuning run.
// [R7] The run steps the trim so the oscillator is centred on its target.
// [R8] Software changes the tune control register only while the hold bit is set.
// [R9] Bit zero of the tune status register reads one once a run has completed.
// [R10] The done flag also reads one when release came with tuning disabled.
// [R11] The tune status register is read-only with its upper seven bits reading zero.
// [R12] Software writes reserved bits of hold and tune control as zero.
// [R13] A calibration enable register has bit zero resetting to one and reserved upper bits.
// [R14] Clearing calibration enable holds calibration and the clock dividers in reset.
// [R15] Setting the hold bit with tuning enabled clears the done flag.
`timescale 1ns/1ps
module sotc_top #(
    parameter int TUNE_SETTLE_BASE_CYCLES = sotc_pkg::SETTLE_BASE_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic       i_spi_cs_n,
    input  wire logic       i_spi_sclk,
    input  wire logic       i_spi_sdi,
    input  wire logic       i_osc_fast,
    output logic            o_spi_sdo,
    output logic            o_spi_sdo_oe,
    output logic            o_synth_hold,
    output logic [6:0]      o_osc_trim_code,
    output logic            o_osc_tune_active,
    output logic            o_osc_tune_finished,
    output logic            o_conv_calib_run,
    output logic            o_clock_div_reset
);

    // =========================================================================
    // Engine states.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_DONE   = 3'b100
    } sotc_state_type;

    sotc_pkg::sotc_reg_req_type req;
    sotc_state_type             state_ff;
    logic [7:0]                 rdata;
    logic [6:0]                 trim_code_ff;
    logic                       synth_hold_ff;
    logic [2:0]                 tune_settle_select_ff;
    logic                       osc_tune_enable_ff;
    logic                       osc_tune_finished_ff;
    logic                       conv_calib_en_ff;
    logic [2:0]                 bit_idx_ff;
    logic                       release_evt;
    logic                       timer_start;
    logic                       expired;
    logic [6:0]                 idx_mask;
    logic [6:0]                 trim_decided;

    // =========================================================================
    // Serial port and settle timer.
    sotc_spi_port u_spi (
        .i_clock      (i_clock),
        .i_srst       (i_srst),
        .i_spi_cs_n   (i_spi_cs_n),
        .i_spi_sclk   (i_spi_sclk),
        .i_spi_sdi    (i_spi_sdi),
        .i_rdata      (rdata),
        .o_req        (req),
        .o_spi_sdo    (o_spi_sdo),
        .o_spi_sdo_oe (o_spi_sdo_oe)
    );

    sotc_settle_timer #(
        .BASE (TUNE_SETTLE_BASE_CYCLES)
    ) u_timer (
        .i_clock   (i_clock),
        .i_srst    (i_srst),
        .i_start   (timer_start),
        .i_sel     (tune_settle_select_ff),
        .o_expired (expired)
    );

    // =========================================================================
    // Write decode shared by the register processes.
    function automatic logic wr_hit(input sotc_pkg::sotc_reg_req_type r, input logic [14:0] a);
        wr_hit = r.wr && r.addr == a;
    endfunction : wr_hit

    // Release is the write that clears a set hold bit.
    assign release_evt = synth_hold_ff && wr_hit(req, sotc_pkg::ADDR_SYNTH_HOLD)
                         && !req.data[sotc_pkg::SYNTH_HOLD_BIT]; // [R6]

    // Hold bit; reserved bits are not stored and read as zero.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            synth_hold_ff <= sotc_pkg::SYNTH_HOLD_RST;
        end else if (wr_hit(req, sotc_pkg::ADDR_SYNTH_HOLD)) begin
            synth_hold_ff <= req.data[sotc_pkg::SYNTH_HOLD_BIT];
        end
    end

    // Tune control; the select is taken at each settle wait start, the enable at once.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tune_settle_select_ff <= sotc_pkg::SETTLE_SEL_RST; // [R5]
            osc_tune_enable_ff    <= sotc_pkg::TUNE_ENABLE_RST;
        end else if (wr_hit(req, sotc_pkg::ADDR_TUNE_CONTROL)) begin
            tune_settle_select_ff <= req.data[sotc_pkg::SETTLE_SEL_MSB:sotc_pkg::SETTLE_SEL_LSB];
            osc_tune_enable_ff    <= req.data[sotc_pkg::TUNE_ENABLE_BIT];
        end
    end

    // Calibration enable; low holds calibration and the dividers in reset.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            conv_calib_en_ff <= sotc_pkg::CALIB_EN_RST; // [R13]
        end else if (wr_hit(req, sotc_pkg::ADDR_CALIB_ENABLE)) begin
            conv_calib_en_ff <= req.data[sotc_pkg::CALIB_EN_BIT];
        end
    end

    assign o_conv_calib_run  = conv_calib_en_ff; // [R14]
    assign o_clock_div_reset = ~conv_calib_en_ff; // [R14]

    // =========================================================================
    // Trim engine: one bit per settle wait, MSB first.
    assign timer_start  = release_evt && osc_tune_enable_ff
                          || state_ff == ST_SETTLE && expired && bit_idx_ff != 3'h0 && !synth_hold_ff;
    assign idx_mask     = 7'h01 << bit_idx_ff;
    assign trim_decided = i_osc_fast ? (trim_code_ff & ~idx_mask) : trim_code_ff; // [R7]

    // A set hold bit aborts a run, so the engine never fights a reprogramming.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff   <= ST_IDLE;
            bit_idx_ff <= sotc_pkg::TRIM_TOP_INDEX;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (release_evt && osc_tune_enable_ff) begin
                        state_ff   <= ST_SETTLE; // [R6]
                        bit_idx_ff <= sotc_pkg::TRIM_TOP_INDEX;
                    end
                end
                ST_SETTLE: begin
                    if (synth_hold_ff) begin
                        state_ff <= ST_IDLE;
                    end else if (expired && bit_idx_ff == 3'h0) begin
                        state_ff <= ST_DONE;
                    end else if (expired) begin
                        bit_idx_ff <= bit_idx_ff - 3'h1;
                    end
                end
                ST_DONE: begin
                    if (synth_hold_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Trim code: engine owns it during a run; serial writes then are dropped.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            trim_code_ff <= sotc_pkg::TRIM_CODE_RST;
        end else if (release_evt && osc_tune_enable_ff) begin
            trim_code_ff <= sotc_pkg::TRIM_CODE_START; // [R7]
        end else if (state_ff == ST_SETTLE && !synth_hold_ff) begin
            if (expired && bit_idx_ff != 3'h0) begin
                trim_code_ff <= trim_decided | (idx_mask >> 1); // [R7]
            end else if (expired) begin
                trim_code_ff <= trim_decided; // [R7]
            end
        end else if (wr_hit(req, sotc_pkg::ADDR_TRIM_VALUE)) begin
            trim_code_ff <= req.data[sotc_pkg::TRIM_CODE_MSB:0]; // [R1]
        end
    end

    // Done flag: set wins over clear, although the two cannot meet today.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            osc_tune_finished_ff <= sotc_pkg::TUNE_DONE_RST;
        end else if (release_evt && !osc_tune_enable_ff) begin
            osc_tune_finished_ff <= 1'h1; // [R10]
        end else if (state_ff == ST_SETTLE && expired && bit_idx_ff == 3'h0 && !synth_hold_ff) begin
            osc_tune_finished_ff <= 1'h1; // [R9]
        end else if (synth_hold_ff && osc_tune_enable_ff) begin
            osc_tune_finished_ff <= 1'h0; // [R15]
        end
    end

    // =========================================================================
    // Read mux; unmapped addresses read zero and reading has no side effect.
    always_comb begin
        rdata = 8'h00;
        case (req.addr)
            sotc_pkg::ADDR_TRIM_VALUE:   rdata = {1'h0, trim_code_ff}; // [R2]
            sotc_pkg::ADDR_SYNTH_HOLD:   rdata = {7'h00, synth_hold_ff};
            sotc_pkg::ADDR_TUNE_CONTROL: rdata = {1'h0, tune_settle_select_ff, 3'h0, osc_tune_enable_ff};
            sotc_pkg::ADDR_TUNE_STATUS:  rdata = {7'h00, osc_tune_finished_ff}; // [R11]
            sotc_pkg::ADDR_CALIB_ENABLE: rdata = {7'h00, conv_calib_en_ff}; // [R13]
            default:                     rdata = 8'h00;
        endcase
    end

    assign o_synth_hold        = synth_hold_ff;
    assign o_osc_trim_code     = trim_code_ff; // [R1]
    assign o_osc_tune_active   = state_ff == ST_SETTLE;
    assign o_osc_tune_finished = osc_tune_finished_ff;

    // =========================================================================
    // Checks.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    a_release_starts: assert property (release_evt && osc_tune_enable_ff // [R6]
        |=> o_osc_tune_active && o_osc_trim_code == 7'h40)
        else $error("Release with tuning enabled did not start a run.");

    a_skip_sets_done: assert property (release_evt && !osc_tune_enable_ff // [R10]
        |=> o_osc_tune_finished && !o_osc_tune_active)
        else $error("Skipped run did not report done.");

    a_run_sets_done: assert property (o_osc_tune_active && expired && bit_idx_ff == 3'h0 && !synth_hold_ff // [R9]
        |=> o_osc_tune_finished && state_ff == ST_DONE)
        else $error("Completed run did not report done.");

    a_hold_clears: assert property (synth_hold_ff && osc_tune_enable_ff && !release_evt // [R15]
        |=> !o_osc_tune_finished)
        else $error("Hold with tuning enabled left done set.");

    a_trim_decides: assert property (o_osc_tune_active && expired && i_osc_fast && !synth_hold_ff // [R7]
        |=> o_osc_trim_code[$past(bit_idx_ff)] == 1'h0)
        else $error("Fast oscillator did not clear the trial bit.");

    a_trim_steady: assert property (o_osc_tune_active && !expired ##1 o_osc_tune_active // [R7]
        |-> $stable(o_osc_trim_code))
        else $error("Trim moved inside a settle wait.");

    a_trim_readback: assert property (req.rd && req.addr == sotc_pkg::ADDR_TRIM_VALUE // [R2]
        |-> rdata == {1'h0, o_osc_trim_code})
        else $error("Trim read does not return the trim code.");

    a_trim_write: assert property (wr_hit(req, sotc_pkg::ADDR_TRIM_VALUE) && state_ff != ST_SETTLE && !release_evt // [R1]
        |=> o_osc_trim_code == $past(req.data[6:0]))
        else $error("Trim write not stored.");

    a_status_reserved: assert property (req.addr == sotc_pkg::ADDR_TUNE_STATUS // [R11]
        |-> rdata[7:1] == 7'h00 && rdata[0] == o_osc_tune_finished)
        else $error("Status read wrong.");

    a_calib_divider: assert property (wr_hit(req, sotc_pkg::ADDR_CALIB_ENABLE) // [R14]
        |=> o_clock_div_reset == !$past(req.data[0]) && o_conv_calib_run == $past(req.data[0]))
        else $error("Calibration enable did not steer the divider reset.");

    c_run_done: cover property (o_osc_tune_active ##1 state_ff == ST_DONE);
    c_skip_done: cover property (release_evt && !osc_tune_enable_ff);
    c_trim_read: cover property (state_ff == ST_DONE && req.rd && req.addr == sotc_pkg::ADDR_TRIM_VALUE);
    c_abort: cover property (o_osc_tune_active && synth_hold_ff);

endmodule : sotc_top

// ==== include/sotc_pkg.sv ====
/*
 * Package of the oscillator tune controller: register map, field positions,
 * reset values, serial frame layout, settle timing and shared types.
 * Assumes it is compiled before every hw/ file and is used by scoped names only.
 */
package sotc_pkg;

    // =========================================================================
    // Register offsets on the serial register port.
    localparam logic [14:0] ADDR_TRIM_VALUE   = 15'h0059;
    localparam logic [14:0] ADDR_SYNTH_HOLD   = 15'h005c;
    localparam logic [14:0] ADDR_TUNE_CONTROL = 15'h005d;
    localparam logic [14:0] ADDR_TUNE_STATUS  = 15'h005e;
    localparam logic [14:0] ADDR_CALIB_ENABLE = 15'h0061;

    // =========================================================================
    // Field positions.
    localparam int TRIM_CODE_MSB   = 6;
    localparam int SYNTH_HOLD_BIT  = 0;
    localparam int TUNE_ENABLE_BIT = 0;
    localparam int SETTLE_SEL_LSB  = 4;
    localparam int SETTLE_SEL_MSB  = 6;
    localparam int TUNE_DONE_BIT   = 0;
    localparam int CALIB_EN_BIT    = 0;

    // =========================================================================
    // Reset values and the first trial code of a tuning run.
    localparam logic [6:0] TRIM_CODE_RST   = 7'h00;
    localparam logic       SYNTH_HOLD_RST  = 1'h0;
    localparam logic [2:0] SETTLE_SEL_RST  = 3'h4;
    localparam logic       TUNE_ENABLE_RST = 1'h0;
    localparam logic       TUNE_DONE_RST   = 1'h0;
    localparam logic       CALIB_EN_RST    = 1'h1;
    localparam logic [6:0] TRIM_CODE_START = 7'h40;
    localparam logic [2:0] TRIM_TOP_INDEX  = 3'h6;

    // =========================================================================
    // Serial frame: one read flag, fifteen address bits, eight data bits.
    localparam logic [4:0] SPI_HDR_LAST   = 5'h0f;
    localparam logic [4:0] SPI_DATA_FIRST = 5'h10;
    localparam logic [4:0] SPI_DATA_SHIFT = 5'h16;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0] SPI_FRAME_END  = 5'h18;

    // =========================================================================
    // Settle time unit in clock cycles; the wait is this unit times two to the select.
    localparam int SETTLE_BASE_CYCLES = 64;

    // One register access taken from the serial port.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  data;
    } sotc_reg_req_type;

endpackage : sotc_pkg

// ==== tb/sotc_top_tb.sv ====
/*
 * Self-checking bench of the oscillator tune controller top.
 * Assumes the design package is compiled first; the bench drives the serial port and detector itself.
 */
`timescale 1ns/1ps
module sotc_top_tb;
    // =========================================================================
    // Stimulus and observed signals.
    localparam int B = 4;
    logic       i_clock = 1'b0, i_srst = 1'b1, i_spi_cs_n = 1'b1, i_spi_sclk = 1'b0;
    logic       i_spi_sdi = 1'b0, i_osc_fast = 1'b0;
    logic       o_spi_sdo, o_spi_sdo_oe, o_synth_hold, o_osc_tune_active;
    logic       o_osc_tune_finished, o_conv_calib_run, o_clock_div_reset;
    logic [6:0] o_osc_trim_code;
    logic [6:0] target = 7'h00;
    logic [7:0] q;
    int         n_mismatch = 0, checks_done = 0, act_cnt = 0;

    sotc_top #(.TUNE_SETTLE_BASE_CYCLES(B)) sotc_top_i (.i_clock(i_clock), .i_srst(i_srst),
        .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk), .i_spi_sdi(i_spi_sdi), .i_osc_fast(i_osc_fast),
        .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe(o_spi_sdo_oe), .o_synth_hold(o_synth_hold),
        .o_osc_trim_code(o_osc_trim_code), .o_osc_tune_active(o_osc_tune_active),
        .o_osc_tune_finished(o_osc_tune_finished), .o_conv_calib_run(o_conv_calib_run),
        .o_clock_div_reset(o_clock_div_reset));

    // The clock toggles every 5 ns for a 100 MHz rate.
    initial begin
        forever #5 i_clock = ~i_clock;
    end

    // Detector stand-in: fast while the trim is above the chosen target, counted active time too.
    always @(posedge i_clock) begin
        i_osc_fast <= (o_osc_trim_code > target);
        act_cnt <= act_cnt + ((o_osc_tune_active === 1'b1) ? 1 : 0);
    end

    // =========================================================================
    // Shared tasks.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    // One 24-bit frame; each serial clock half lasts four system clocks, read bits sampled at rises.
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] r);
        logic [23:0] f;
        f = {rd, a, d};
        r = 8'h00;
        @(posedge i_clock) i_spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            i_spi_sdi <= f[i];
            repeat (4) @(posedge i_clock);
            if (i < 8) r[i] = o_spi_sdo;
            i_spi_sclk <= 1'b1;
            repeat (4) @(posedge i_clock);
            i_spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clock);
        chk({7'h00, o_spi_sdo_oe}, {7'h00, rd});
        i_spi_cs_n <= 1'b1;
        repeat (4) @(posedge i_clock);
    endtask : xfer

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(1'b0, a, d, dummy);
    endtask : wr

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // =========================================================================
    // Scenarios.
    task automatic t_reset_map();
        xfer(1'b1, sotc_pkg::ADDR_TUNE_CONTROL, 8'h00, q); chk(q, 8'h40);
        xfer(1'b1, sotc_pkg::ADDR_SYNTH_HOLD, 8'h00, q);   chk(q, 8'h00);
        xfer(1'b1, sotc_pkg::ADDR_CALIB_ENABLE, 8'h00, q); chk(q, 8'h01);
        xfer(1'b1, 15'h0070, 8'h00, q);                    chk(q, 8'h00);
        wr(sotc_pkg::ADDR_TUNE_STATUS, 8'hff);
        xfer(1'b1, sotc_pkg::ADDR_TUNE_STATUS, 8'h00, q);  chk(q, 8'h00);
        wr(sotc_pkg::ADDR_CALIB_ENABLE, 8'h00);
        chk({6'h00, o_conv_calib_run, o_clock_div_reset}, 8'h01);
        wr(sotc_pkg::ADDR_CALIB_ENABLE, 8'h01);
        chk({6'h00, o_conv_calib_run, o_clock_div_reset}, 8'h02);
    endtask : t_reset_map

    // Release with tuning disabled still reports done.
    task automatic t_skip();
        wr(sotc_pkg::ADDR_SYNTH_HOLD, 8'h01);
        chk({7'h00, o_synth_hold}, 8'h01);
        wr(sotc_pkg::ADDR_TUNE_CONTROL, 8'h00);
        wr(sotc_pkg::ADDR_SYNTH_HOLD, 8'h00);
        xfer(1'b1, sotc_pkg::ADDR_TUNE_STATUS, 8'h00, q); chk(q, 8'h01);
    endtask : t_skip

    // Full run: done clears on hold, trim ends on target and reads back, wait grows with select.
    task automatic t_run(input logic [2:0] sel, input logic [6:0] tgt);
        int w;
        int a0;
        target = tgt;
        w = B << sel;
        wr(sotc_pkg::ADDR_SYNTH_HOLD, 8'h01);
        wr(sotc_pkg::ADDR_TUNE_CONTROL, {1'b0, sel, 4'h1});
        chk({7'h00, o_osc_tune_finished}, 8'h00);
        // The active count is taken as a difference, so the run started inside the frame is counted whole.
        a0 = act_cnt;
        wr(sotc_pkg::ADDR_SYNTH_HOLD, 8'h00);
        for (int i = 0; i < 2000 && o_osc_tune_finished !== 1'b1; i++) @(posedge i_clock);
        chk({7'h00, o_osc_tune_finished}, 8'h01);
        chk({1'b0, o_osc_trim_code}, {1'b0, tgt});
        chk({7'h00, (act_cnt - a0 >= 7 * w - 8) && (act_cnt - a0 <= 7 * w + 40)}, 8'h01);
        xfer(1'b1, sotc_pkg::ADDR_TRIM_VALUE, 8'h00, q); chk(q, {1'b0, tgt});
    endtask : t_run

    // Saved trim written back while idle is kept and driven out.
    task automatic t_restore();
        wr(sotc_pkg::ADDR_SYNTH_HOLD, 8'h01);
        wr(sotc_pkg::ADDR_TRIM_VALUE, 8'h11);
        chk({1'b0, o_osc_trim_code}, 8'h11);
        xfer(1'b1, sotc_pkg::ADDR_TRIM_VALUE, 8'h00, q); chk(q, 8'h11);
    endtask : t_restore

    // =========================================================================
    // Main sequence: reset for two cycles, then the scenarios.
    initial begin
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        t_reset_map();
        t_skip();
        t_run(3'h0, 7'h2b);
        t_run(3'h2, 7'h55);
        t_restore();
        end_of_test();
    end

    // Watchdog well beyond the expected run of about five thousand cycles.
    initial begin
        repeat (60000) @(posedge i_clock);
        n_mismatch++;
        end_of_test();
    end
endmodule : sotc_top_tb
